// File: src/lpddr_mode_register_burst_sequencer.v
// Mode register decode and burst sequencing for a low power DDR device
`timescale 1ns/1ps
`include "lpddr_seq_consts.vh"
module lpddr_mode_register_burst_sequencer (
    input wire clk,
    input wire rst_n,
    input wire [1:0] cmd,
    input wire bank_select_high,
    input wire bank_select_low,
    input wire [12:0] addr,
    output reg [14:0] standard_mode_config,
    output reg [2:0] read_latency_cycles,
    output reg [4:0] burst_beats,
    output reg burst_order_select,
    output reg modeValid,
    output reg readActive,
    output reg writeActive,
    output reg dataValid,
    output reg [`COL_WIDTH-1:0] colEven,
    output reg [`COL_WIDTH-1:0] colOdd,
    output reg burstDone
);
    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    function [4:0] beatsOf;
        input [2:0] code;
        begin
            case (code)
                `LEN_CODE_2: beatsOf = 5'h02;
                `LEN_CODE_4: beatsOf = 5'h04;
                `LEN_CODE_8: beatsOf = 5'h08;
                `LEN_CODE_16: beatsOf = 5'h10;
                default: beatsOf = 5'h00;
            endcase
        end
    endfunction

    function [3:0] maskOf;
        input [4:0] beats;
        begin
            maskOf = beats[3:0] - 4'h1;
            if (beats[4]) begin
                maskOf = 4'hF;
            end
        end
    endfunction

    function latIsLegal;
        input [2:0] code;
        begin
            latIsLegal = (code == `LAT_CODE_2) || (code == `LAT_CODE_3);
        end
    endfunction

    // Reserved codes only raise a flag; the block keeps running on them
    function modeOk;
        input [12:0] word;
        begin
            modeOk = (word[`MR_OPMODE_MSB:`MR_OPMODE_LSB] == 6'h00)
                && (beatsOf(word[`MR_LEN_MSB:`MR_LEN_LSB]) != 5'h00)
                && latIsLegal(word[`MR_LAT_MSB:`MR_LAT_LSB]);
        end
    endfunction

    // Idle cycles before the first transfer; any code but three acts as two
    function [1:0] waitOf;
        input [2:0] code;
        begin
            if (code == `LAT_CODE_3) begin
                waitOf = `LAT3_WAIT;
            end else begin
                waitOf = 2'h0;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // State codes
    // ------------------------------------------------------------
    localparam IDLE = 2'h0;
    localparam WAIT = 2'h1;
    localparam XFER = 2'h2;

    // ------------------------------------------------------------
    // Mode register load
    // ------------------------------------------------------------
    wire [1:0] target;
    wire [14:0] loadWord;
    assign target = {bank_select_high, bank_select_low};
    assign loadWord = {target, addr};

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            standard_mode_config <= `MR_RESET_VALUE;
            read_latency_cycles <= `LAT_CODE_2;
            burst_beats <= 5'h04;
            burst_order_select <= 1'b0;
            modeValid <= 1'b1;
        end else if (cmd == `CMD_LOAD_MODE && target == `SEL_STANDARD) begin
            // Other targets leave this register untouched
            standard_mode_config <= loadWord;
            read_latency_cycles <= addr[`MR_LAT_MSB:`MR_LAT_LSB];
            burst_beats <= beatsOf(addr[`MR_LEN_MSB:`MR_LEN_LSB]);
            burst_order_select <= addr[`MR_ORDER_BIT];
            modeValid <= modeOk(addr);
        end
    end

    // ------------------------------------------------------------
    // Burst sequencer
    // ------------------------------------------------------------
    reg [1:0] state_q;
    reg [1:0] wait_q;
    reg [3:0] beat_q;
    reg [`COL_WIDTH-1:0] start_q;
    wire [3:0] lowMask;
    wire [`COL_WIDTH-1:0] colA;
    wire [`COL_WIDTH-1:0] colB;
    wire [3:0] beatNext;
    wire [3:0] beatLast;
    wire isAccess;
    assign lowMask = maskOf(burst_beats);
    assign beatNext = beat_q + 4'h1;
    assign beatLast = lowMask;
    assign isAccess = (cmd == `CMD_READ) || (cmd == `CMD_WRITE);

    // ------------------------------------------------------------
    // Column generators
    // ------------------------------------------------------------
    burst_column_gen genEven (
        .startCol(start_q),
        .beat(beat_q),
        .lowMask(lowMask),
        .interleaved(burst_order_select),
        .colAddr(colA)
    );
    burst_column_gen genOdd (
        .startCol(start_q),
        .beat(beatNext),
        .lowMask(lowMask),
        .interleaved(burst_order_select),
        .colAddr(colB)
    );

    // ------------------------------------------------------------
    // Transfer state machine
    // ------------------------------------------------------------
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= IDLE;
            wait_q <= 2'h0;
            beat_q <= 4'h0;
            start_q <= {`COL_WIDTH{1'b0}};
            readActive <= 1'b0;
            writeActive <= 1'b0;
            dataValid <= 1'b0;
            colEven <= {`COL_WIDTH{1'b0}};
            colOdd <= {`COL_WIDTH{1'b0}};
            burstDone <= 1'b0;
        end else begin
            burstDone <= 1'b0;
            dataValid <= 1'b0;
            case (state_q)
                IDLE: begin
                    if (isAccess) begin
                        start_q <= addr[`COL_WIDTH-1:0];
                        beat_q <= 4'h0;
                        readActive <= (cmd == `CMD_READ);
                        writeActive <= (cmd == `CMD_WRITE);
                        // Read waits latency minus two; write starts next
                        if (cmd == `CMD_READ &&
                            waitOf(read_latency_cycles) != 2'h0) begin
                            wait_q <= waitOf(read_latency_cycles);
                            state_q <= WAIT;
                        end else begin
                            state_q <= XFER;
                        end
                    end
                end
                WAIT: begin
                    if (wait_q == 2'h1) begin
                        state_q <= XFER;
                    end
                    wait_q <= wait_q - 2'h1;
                end
                XFER: begin
                    // Two words per clock: one per half cycle
                    dataValid <= 1'b1;
                    colEven <= colA;
                    colOdd <= colB;
                    // Beat count steps by two; the odd word takes beatNext
                    beat_q <= beat_q + 4'h2;
                    if (beatNext == beatLast) begin
                        burstDone <= 1'b1;
                        readActive <= 1'b0;
                        writeActive <= 1'b0;
                        state_q <= IDLE;
                    end
                end
                default: begin
                    state_q <= IDLE;
                end
            endcase
        end
    end
endmodule // lpddr_mode_register_burst_sequencer

// File: src/lpddr_seq_consts.vh
// Constants for the mode register burst sequencer
`ifndef LPDDR_SEQ_CONSTS_VH
`define LPDDR_SEQ_CONSTS_VH
`define MR_WIDTH 15
`define MR_LEN_LSB 0
`define MR_LEN_MSB 2
`define MR_ORDER_BIT 3
`define MR_LAT_LSB 4
`define MR_LAT_MSB 6
`define MR_OPMODE_LSB 7
`define MR_OPMODE_MSB 12
`define MR_BANK_LSB 13
`define MR_BANK_MSB 14
`define MR_RESET_VALUE 15'h0022
`define SEL_STANDARD 2'h0
`define SEL_STATUS 2'h1
`define SEL_EXTENDED 2'h2
`define LAT_CODE_2 3'h2
`define LAT_CODE_3 3'h3
`define LAT3_WAIT 2'h1
`define LEN_CODE_2 3'h1
`define LEN_CODE_4 3'h2
`define LEN_CODE_8 3'h3
`define LEN_CODE_16 3'h4
`define CMD_NOP 2'h0
`define CMD_LOAD_MODE 2'h1
`define CMD_READ 2'h2
`define CMD_WRITE 2'h3
`define COL_WIDTH 10
`endif

// File: src/burst_column_gen.v
// Column address generator for one burst beat
`timescale 1ns/1ps
`include "lpddr_seq_consts.vh"
module burst_column_gen (
    input wire [`COL_WIDTH-1:0] startCol,
    input wire [3:0] beat,
    input wire [3:0] lowMask,
    input wire interleaved,
    output wire [`COL_WIDTH-1:0] colAddr
);
    wire [3:0] startLow;
    wire [3:0] seqLow;
    wire [3:0] intLow;
    wire [3:0] newLow;
    assign startLow = startCol[3:0];
    assign seqLow = (startLow + beat) & lowMask;
    assign intLow = (startLow ^ beat) & lowMask;
    assign newLow = interleaved ? intLow : seqLow;
    // Block bits above the mask stay those of the start column
    assign colAddr = {startCol[`COL_WIDTH-1:4],
        (startLow & ~lowMask) | newLow};
endmodule // burst_column_gen

// File: testbench/seq_chk_sva.sv
// Port checker for the burst sequencer
`timescale 1ns/1ps
module seq_chk (
    input wire clk,
    input wire rst_n,
    input wire [1:0] cmd,
    input wire bank_select_high,
    input wire bank_select_low,
    input wire [12:0] addr,
    input wire [14:0] standard_mode_config,
    input wire [2:0] read_latency_cycles,
    input wire [4:0] burst_beats,
    input wire burst_order_select,
    input wire readActive,
    input wire writeActive,
    input wire dataValid,
    input wire [9:0] colEven,
    input wire [9:0] colOdd,
    input wire burstDone
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire go = (!readActive && !writeActive) || burstDone;
    wire rdGo = cmd == 2'h2 && go;
    wire load = cmd == 2'h1 && !bank_select_high && !bank_select_low;
    wire [9:0] m = {6'h0, burst_beats[3:0] - 4'h1};
    reg [3:0] beatCnt_q;
    // Counts transfer cycles so burst length is checked whatever its size
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) beatCnt_q <= 4'h0;
        else if (burstDone) beatCnt_q <= 4'h0;
        else if (dataValid) beatCnt_q <= beatCnt_q + 4'h1;
    end
    a_lat_two: assert property (rdGo && read_latency_cycles == 3'h2
        |=> !dataValid ##1 dataValid) else $error("latency two wrong");
    a_lat_three: assert property (rdGo && read_latency_cycles == 3'h3
        |=> !dataValid ##1 !dataValid ##1 dataValid)
        else $error("latency three wrong");
    a_wr_start: assert property (go && cmd == 2'h3
        |=> !dataValid ##1 dataValid) else $error("write start wrong");
    a_dir_flags: assert property (go && cmd[1]
        |=> readActive == ($past(cmd) == 2'h2)
        && writeActive == ($past(cmd) == 2'h3))
        else $error("direction flags");
    a_std_load: assert property (load
        |=> standard_mode_config == {2'h0, $past(addr)}) else $error("load");
    a_len_decode: assert property (load && addr[2:0] != 3'h0
        && addr[2:0] < 3'h5 |=> burst_beats == 5'h1 << $past(addr[2:0]))
        else $error("burst length");
    a_order_bit: assert property (load
        |=> burst_order_select == $past(addr[3])) else $error("order");
    a_seq_wrap: assert property (dataValid && !burst_order_select
        |-> colOdd == ((colEven & ~m) | ((colEven + 10'h1) & m)))
        else $error("sequential wrap");
    a_ilv_pair: assert property (dataValid && burst_order_select
        |-> colOdd == (colEven ^ 10'h1)) else $error("interleave");
    a_burst_len: assert property (burstDone
        |-> dataValid && beatCnt_q == burst_beats[4:1] - 4'h1)
        else $error("burst length count");
    cover property (rdGo && read_latency_cycles == 3'h3);
    cover property (burstDone && burst_beats == 5'h10);
    cover property (cmd == 2'h3 && burstDone);
endmodule // seq_chk
bind lpddr_mode_register_burst_sequencer seq_chk u_chk (.clk, .rst_n, .cmd,
    .bank_select_high, .bank_select_low, .addr, .standard_mode_config,
    .read_latency_cycles, .burst_beats, .burst_order_select, .readActive,
    .writeActive, .dataValid, .colEven, .colOdd, .burstDone);

// File: testbench/ctrl_model.sv
// Memory controller model driving command and address
`timescale 1ns/1ps
module ctrl_model (
    input wire clk,
    input wire busy,
    input wire done,
    output reg [1:0] cmd,
    output reg bankHi,
    output reg bankLo,
    output reg [12:0] addr
);
    initial {cmd, bankHi, bankLo, addr} = 17'h0;
    task issue(input [1:0] c, input [1:0] b, input [12:0] a);
        @(posedge clk);
        #1;
        while (busy && !done) begin
            @(posedge clk);
            #1;
        end
        {cmd, bankHi, bankLo, addr} = {c, b, a};
        @(posedge clk);
        #1;
        // Address is not held after the command, so show a changed value
        {cmd, addr} = {2'h0, ~a};
        if (c == 2'h1) #8;
    endtask
endmodule // ctrl_model

// File: testbench/tb_lpddr_mode_register_burst_sequencer.sv
// Self-checking bench for the burst sequencer
`timescale 1ns/1ps
module tb_lpddr_mode_register_burst_sequencer;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire [1:0] cmd;
    wire bankHi, bankLo, ord, modeOk, rdAct, wrAct, dv, done;
    wire [12:0] addr;
    wire [14:0] cfg;
    wire [2:0] lat;
    wire [4:0] beats;
    wire [9:0] colE, colO;
    logic [19:0] expQ[$];
    int err_total = 0;
    int compares = 0;
    int cyc = 0;
    always #2 clk = ~clk;
    lpddr_mode_register_burst_sequencer u_dut (.clk, .rst_n, .cmd,
        .bank_select_high(bankHi), .bank_select_low(bankLo), .addr,
        .standard_mode_config(cfg), .read_latency_cycles(lat),
        .burst_beats(beats), .burst_order_select(ord), .modeValid(modeOk),
        .readActive(rdAct), .writeActive(wrAct), .dataValid(dv),
        .colEven(colE), .colOdd(colO), .burstDone(done));
    ctrl_model u_ctrl (.clk, .busy(rdAct | wrAct), .done, .cmd, .bankHi,
        .bankLo, .addr);
    task chk_val(input string n, input logic [19:0] e, g);
        compares++;
        if (e !== g) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask
    task chk_col(input logic [19:0] e, g);
        chk_val("columns", e, g);
    endtask
    function automatic logic [9:0] colAt(logic [9:0] s, m, int k, logic ilv);
        return (s & ~m) | ((ilv ? s ^ 10'(k) : s + 10'(k)) & m);
    endfunction
    task burst(input [1:0] c, input [2:0] blc, input ilv);
        logic [9:0] s, m;
        s = 10'($urandom);
        m = (10'h1 << blc) - 10'h1;
        for (int k = 0; k < (1 << blc); k += 2)
            expQ.push_back({colAt(s, m, k, ilv), colAt(s, m, k + 1, ilv)});
        u_ctrl.issue(c, 2'h0, {3'h0, s});
    endtask
    always @(negedge clk) begin
        if (dv === 1'b1) begin
            if (expQ.size() == 0) chk_col('x, {colE, colO});
            else chk_col(expQ.pop_front(), {colE, colO});
        end
    end
    task wrap_up;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            wrap_up;
        end
    end
    initial begin
        logic [12:0] mode;
        void'($urandom(71));
        repeat (5) @(posedge clk);
        #1 rst_n = 1'b1;
        chk_val("config", 20'h22, cfg);
        chk_val("modeValid", 20'h1, modeOk);
        for (int i = 0; i < 16; i++) begin
            mode = {6'h0, 3'h2 + 3'(i[3]), i[0], 3'h1 + 3'(i[2:1])};
            u_ctrl.issue(2'h1, 2'h0, mode);
            chk_val("config", mode, cfg);
            chk_val("latency", mode[6:4], lat);
            chk_val("beats", 20'h1 << mode[2:0], beats);
            chk_val("order", mode[3], ord);
            chk_val("modeValid", 20'h1, modeOk);
            u_ctrl.issue(2'h1, 2'(1 + i[0]), 13'h0);
            chk_val("config", mode, cfg);
            burst(2'h2, mode[2:0], mode[3]);
            repeat ($urandom % 2) @(posedge clk);
            burst(2'h3, mode[2:0], mode[3]);
        end
        // Deliberate reserved load: only the flag is looked at afterwards
        u_ctrl.issue(2'h1, 2'h0, 13'h00A2);
        chk_val("modeValid", 20'h0, modeOk);
        repeat (20) @(posedge clk);
        chk_val("pending", 20'h0, expQ.size());
        wrap_up;
    end
endmodule // tb_lpddr_mode_register_burst_sequencer
